/* verilog/tpm_pkg.sv */
package tpm_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PSC_W = 4;
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_MODE = 4'h1;
	localparam logic [3:0] A_PSC = 4'h2;
	localparam logic [3:0] A_LOW0 = 4'h3;
	localparam logic [3:0] A_HIGH0 = 4'h4;
	localparam logic [3:0] A_LREL0 = 4'h5;
	localparam logic [3:0] A_HREL0 = 4'h6;
	localparam logic [3:0] A_LOW1 = 4'h7;
	localparam logic [3:0] A_HIGH1 = 4'h8;
	localparam logic [3:0] A_LREL1 = 4'h9;
	localparam logic [3:0] A_HREL1 = 4'hA;
	localparam logic [3:0] A_STAT = 4'hB;
	localparam logic [3:0] A_MASK = 4'hC;
	localparam logic [3:0] A_PINS = 4'hD;
	localparam logic [3:0] A_CMP0 = 4'hE;
	localparam logic [3:0] A_CMP1 = 4'hF;
	localparam int RUN0_BIT = 0;
	localparam int RUN1_BIT = 1;
	localparam int GATE0_BIT = 2;
	localparam int GATE1_BIT = 3;
	localparam int PWM0_BIT = 4;
	localparam int PWM1_BIT = 5;
	localparam int MODE0_POS = 0;
	localparam int MODE1_POS = 2;
	localparam logic [1:0] MODE_LOG = 2'h0;
	localparam logic [1:0] MODE_LIN = 2'h1;
	localparam logic [1:0] MODE_FREQ = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam int OVF0_BIT = 0;
	localparam int OVF1_BIT = 1;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] PSC_RST = 4'h0;
	localparam logic [1:0] FLAG_RST = 2'h0;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_ZERO = 8'h00;
endpackage

/* verilog/tpm_prescale.sv */
`timescale 1ns/10ps
module tpm_prescale (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [tpm_pkg::PSC_W-1:0] psc_val_in,
	output logic tick_out
);
	logic [tpm_pkg::PSC_W-1:0] cnt_r;

	// one enable pulse every psc_val+1 clocks
	assign tick_out = (cnt_r >= psc_val_in);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_r <= tpm_pkg::PSC_RST;
		end else if (tick_out) begin
			cnt_r <= tpm_pkg::PSC_RST;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

/* verilog/tpm_cmp.sv */
`timescale 1ns/10ps
module tpm_cmp (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic step_in,
	input wire logic [7:0] cnt_nxt_in,
	input wire logic [7:0] duty_in,
	input wire logic toggle_in,
	output logic wave_out,
	output logic [7:0] cmp_out
);
	logic [7:0] cmp_r;
	logic wave_r;

	assign wave_out = wave_r;
	assign cmp_out = cmp_r;

	// duty only latched at wrap, so mid-period writes cannot glitch
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cmp_r <= tpm_pkg::BYTE_RST;
		end else if (step_in && cnt_nxt_in == tpm_pkg::CNT_ZERO) begin
			cmp_r <= duty_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wave_r <= 1'b0;
		end else if (toggle_in) begin
			wave_r <= ~wave_r;
		end else if (step_in) begin
			if (cnt_nxt_in == tpm_pkg::CNT_ZERO) begin
				// zero duty keeps the pin low all period
				wave_r <= (duty_in != tpm_pkg::CNT_ZERO);
			end else if (cnt_nxt_in == cmp_r) begin
				wave_r <= 1'b0;
			end
		end
	end
endmodule

/* verilog/tpm_top.sv */
`timescale 1ns/10ps
module tpm_top (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic [tpm_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [tpm_pkg::DATA_W-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [tpm_pkg::DATA_W-1:0] RDATA_OUT,
	input wire logic EXT_EXT_INTERRUPT0_PIN_PIN_IN,
	input wire logic EXT_INT1_PIN_IN,
	output logic TIMER0_PIN_OUT,
	output logic TIMER1_PIN_OUT,
	output logic BAUD_TICK_OUT,
	output logic IRQ_OUT
);
	logic [7:0] ctrl_r;
	logic [7:0] mode_r;
	logic [3:0] psc_r;
	logic [7:0] low0_r;
	logic [7:0] high0_r;
	logic [7:0] lrel0_r;
	logic [7:0] hrel0_r;
	logic [7:0] low1_r;
	logic [7:0] high1_r;
	logic [7:0] lrel1_r;
	logic [7:0] hrel1_r;
	logic [1:0] stat_r;
	logic [1:0] mask_r;
	logic [7:0] rdata_r;
	logic [2:0] ext_interrupt0_pin_sync_r;
	logic [2:0] int1_sync_r;
	logic ext_interrupt0_pin_lvl_r;
	logic int1_lvl_r;
	logic pin0_r;
	logic pin1_r;
	logic baud_r;
	logic tick;
	logic [1:0] mode0;
	logic [1:0] mode1;
	logic split0;
	logic lin0;
	logic lin1;
	logic en0;
	logic en1;
	logic en0h;
	logic low0_ovf;
	logic low1_ovf;
	logic high0_step;
	logic high1_step;
	logic high0_ovf;
	logic high1_ovf;
	logic ovf1_own;
	logic [1:0] flag_set;
	logic cmp0_step;
	logic cmp1_step;
	logic [7:0] cmp0_cnt;
	logic [7:0] cmp1_cnt;
	logic [7:0] cmp0_duty;
	logic [7:0] cmp1_duty;
	logic cmp0_tog;
	logic cmp1_tog;
	logic wave0;
	logic wave1;
	logic [7:0] cmp0_val;
	logic [7:0] cmp1_val;
	logic [7:0] rd_mux;

	function automatic logic wr_at(input logic wr, input logic [3:0] a,
		input logic [3:0] sel);
		return wr && (a == sel);
	endfunction

	function automatic logic [7:0] inc8(input logic [7:0] v);
		return 8'(v + 8'h01);
	endfunction

	// next low byte: reload source depends on mode
	function automatic logic [7:0] low_nxt(input logic [1:0] m,
		input logic [7:0] low, input logic [7:0] lrel,
		input logic [7:0] high);
		logic [7:0] r;
		r = inc8(low);
		if (low == tpm_pkg::CNT_MAX) begin
			if (m == tpm_pkg::MODE_FREQ) begin
				r = high;
			end else if (m != tpm_pkg::MODE_SPLIT) begin
				r = lrel;
			end
		end
		return r;
	endfunction

	assign mode0 = mode_r[tpm_pkg::MODE0_POS +: 2];
	assign mode1 = mode_r[tpm_pkg::MODE1_POS +: 2];
	assign split0 = (mode0 == tpm_pkg::MODE_SPLIT);
	assign lin0 = (mode0 == tpm_pkg::MODE_LIN) || (mode0 == tpm_pkg::MODE_LOG);
	assign lin1 = (mode1 == tpm_pkg::MODE_LIN) || (mode1 == tpm_pkg::MODE_LOG);

	tpm_prescale u_psc (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.psc_val_in(psc_r),
		.tick_out(tick)
	);

	// gate: count only while the external pin is high
	assign en0 = tick && ctrl_r[tpm_pkg::RUN0_BIT]
		&& (!ctrl_r[tpm_pkg::GATE0_BIT] || ext_interrupt0_pin_lvl_r);
	// own mode 3 freezes timer 1 like a cleared run bit
	assign en1 = tick && ctrl_r[tpm_pkg::RUN1_BIT]
		&& (!ctrl_r[tpm_pkg::GATE1_BIT] || int1_lvl_r)
		&& (mode1 != tpm_pkg::MODE_SPLIT);
	// split high byte: plain timer on run bit 1, no gate
	assign en0h = tick && ctrl_r[tpm_pkg::RUN1_BIT];

	assign low0_ovf = en0 && (low0_r == tpm_pkg::CNT_MAX);
	assign low1_ovf = en1 && (low1_r == tpm_pkg::CNT_MAX);
	assign high0_step = split0 ? en0h : (lin0 && low0_ovf);
	assign high1_step = lin1 && low1_ovf;
	assign high0_ovf = high0_step && (high0_r == tpm_pkg::CNT_MAX);
	assign high1_ovf = high1_step && (high1_r == tpm_pkg::CNT_MAX);
	assign ovf1_own = (mode1 == tpm_pkg::MODE_FREQ) ? low1_ovf : high1_ovf;
	// flags keep working in every mode
	assign flag_set[tpm_pkg::OVF0_BIT] = lin0 ? high0_ovf : low0_ovf;
	assign flag_set[tpm_pkg::OVF1_BIT] = split0 ? high0_ovf : ovf1_own;

	// channel 0: high byte in modes 0/1, low byte in split
	assign cmp0_step = split0 ? en0 : high0_step;
	assign cmp0_cnt = split0 ? inc8(low0_r) : inc8(high0_r);
	assign cmp0_duty = split0 ? lrel0_r : hrel0_r;
	assign cmp0_tog = (mode0 == tpm_pkg::MODE_FREQ) && low0_ovf;
	assign cmp1_step = split0 ? en0h : high1_step;
	assign cmp1_cnt = split0 ? inc8(high0_r) : inc8(high1_r);
	assign cmp1_duty = split0 ? hrel0_r : hrel1_r;
	assign cmp1_tog = !split0 && (mode1 == tpm_pkg::MODE_FREQ) && low1_ovf;

	tpm_cmp u_cmp0 (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.step_in(cmp0_step),
		.cnt_nxt_in(cmp0_cnt),
		.duty_in(cmp0_duty),
		.toggle_in(cmp0_tog),
		.wave_out(wave0),
		.cmp_out(cmp0_val)
	);

	tpm_cmp u_cmp1 (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.step_in(cmp1_step),
		.cnt_nxt_in(cmp1_cnt),
		.duty_in(cmp1_duty),
		.toggle_in(cmp1_tog),
		.wave_out(wave1),
		.cmp_out(cmp1_val)
	);

	// three stages; a level change counts once stages 2 and 3 agree
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ext_interrupt0_pin_sync_r <= 3'h0;
			int1_sync_r <= 3'h0;
			ext_interrupt0_pin_lvl_r <= 1'b0;
			int1_lvl_r <= 1'b0;
		end else begin
			ext_interrupt0_pin_sync_r <= {ext_interrupt0_pin_sync_r[1:0], EXT_EXT_INTERRUPT0_PIN_PIN_IN};
			int1_sync_r <= {int1_sync_r[1:0], EXT_INT1_PIN_IN};
			if (ext_interrupt0_pin_sync_r[1] == ext_interrupt0_pin_sync_r[2]) begin
				ext_interrupt0_pin_lvl_r <= ext_interrupt0_pin_sync_r[2];
			end
			if (int1_sync_r[1] == int1_sync_r[2]) begin
				int1_lvl_r <= int1_sync_r[2];
			end
		end
	end

	// control registers; reload bytes are plain storage in mode 2
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ctrl_r <= tpm_pkg::CTRL_RST;
			mode_r <= tpm_pkg::MODE_RST;
			psc_r <= tpm_pkg::PSC_RST;
			lrel0_r <= tpm_pkg::BYTE_RST;
			hrel0_r <= tpm_pkg::BYTE_RST;
			lrel1_r <= tpm_pkg::BYTE_RST;
			hrel1_r <= tpm_pkg::BYTE_RST;
			mask_r <= tpm_pkg::FLAG_RST;
		end else if (WR_IN) begin
			case (ADDR_IN)
				tpm_pkg::A_CTRL: ctrl_r <= WDATA_IN;
				tpm_pkg::A_MODE: mode_r <= WDATA_IN;
				tpm_pkg::A_PSC: psc_r <= WDATA_IN[3:0];
				tpm_pkg::A_LREL0: lrel0_r <= WDATA_IN;
				tpm_pkg::A_HREL0: hrel0_r <= WDATA_IN;
				tpm_pkg::A_LREL1: lrel1_r <= WDATA_IN;
				tpm_pkg::A_HREL1: hrel1_r <= WDATA_IN;
				tpm_pkg::A_MASK: mask_r <= WDATA_IN[1:0];
				default: ;
			endcase
		end
	end

	// software writes win over a count step in the same cycle
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			low0_r <= tpm_pkg::BYTE_RST;
			high0_r <= tpm_pkg::BYTE_RST;
		end else begin
			if (wr_at(WR_IN, ADDR_IN, tpm_pkg::A_LOW0)) begin
				low0_r <= WDATA_IN;
			end else if (en0) begin
				low0_r <= low_nxt(mode0, low0_r, lrel0_r, high0_r);
			end
			if (wr_at(WR_IN, ADDR_IN, tpm_pkg::A_HIGH0)) begin
				high0_r <= WDATA_IN;
			end else if (high0_step) begin
				high0_r <= inc8(high0_r);
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			low1_r <= tpm_pkg::BYTE_RST;
			high1_r <= tpm_pkg::BYTE_RST;
		end else begin
			if (wr_at(WR_IN, ADDR_IN, tpm_pkg::A_LOW1)) begin
				low1_r <= WDATA_IN;
			end else if (en1) begin
				low1_r <= low_nxt(mode1, low1_r, lrel1_r, high1_r);
			end
			if (wr_at(WR_IN, ADDR_IN, tpm_pkg::A_HIGH1)) begin
				high1_r <= WDATA_IN;
			end else if (high1_step) begin
				high1_r <= inc8(high1_r);
			end
		end
	end

	// sticky flags, cleared by reading; a new event wins the clear
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			stat_r <= tpm_pkg::FLAG_RST;
		end else if (RD_IN && ADDR_IN == tpm_pkg::A_STAT) begin
			stat_r <= flag_set;
		end else begin
			stat_r <= stat_r | flag_set;
		end
	end

	// idle pin reads high like a released port line
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			pin0_r <= 1'b1;
			pin1_r <= 1'b1;
			baud_r <= 1'b0;
		end else begin
			pin0_r <= ctrl_r[tpm_pkg::PWM0_BIT] ? wave0 : 1'b1;
			pin1_r <= ctrl_r[tpm_pkg::PWM1_BIT] ? wave1 : 1'b1;
			baud_r <= ovf1_own;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		case (ADDR_IN)
			tpm_pkg::A_CTRL: rd_mux = ctrl_r;
			tpm_pkg::A_MODE: rd_mux = mode_r;
			tpm_pkg::A_PSC: rd_mux = {4'h0, psc_r};
			tpm_pkg::A_LOW0: rd_mux = low0_r;
			tpm_pkg::A_HIGH0: rd_mux = high0_r;
			tpm_pkg::A_LREL0: rd_mux = lrel0_r;
			tpm_pkg::A_HREL0: rd_mux = hrel0_r;
			tpm_pkg::A_LOW1: rd_mux = low1_r;
			tpm_pkg::A_HIGH1: rd_mux = high1_r;
			tpm_pkg::A_LREL1: rd_mux = lrel1_r;
			tpm_pkg::A_HREL1: rd_mux = hrel1_r;
			tpm_pkg::A_STAT: rd_mux = {6'h00, stat_r};
			tpm_pkg::A_MASK: rd_mux = {6'h00, mask_r};
			tpm_pkg::A_PINS: rd_mux = {6'h00, wave1, wave0};
			tpm_pkg::A_CMP0: rd_mux = cmp0_val;
			tpm_pkg::A_CMP1: rd_mux = cmp1_val;
			default: rd_mux = 8'h00;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= RD_IN ? rd_mux : 8'h00;
		end
	end

	assign RDATA_OUT = rdata_r;
	assign TIMER0_PIN_OUT = pin0_r;
	assign TIMER1_PIN_OUT = pin1_r;
	assign BAUD_TICK_OUT = baud_r;
	assign IRQ_OUT = |(stat_r & mask_r);

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	a_psc_spacing: assert property (
		tick && psc_r == 4'h1 && !wr_at(WR_IN, ADDR_IN, tpm_pkg::A_PSC)
		|=> !tick ##1 tick)
		else $error("prescaler pulse spacing wrong");

	a_low_reload: assert property (
		lin0 && low0_ovf && !wr_at(WR_IN, ADDR_IN, tpm_pkg::A_LOW0)
		|=> low0_r == $past(lrel0_r))
		else $error("low byte not reloaded from low reload");

	a_duty_copy: assert property (
		!split0 && high0_ovf |=> cmp0_val == $past(hrel0_r)
		&& wave0 == ($past(hrel0_r) != 8'h00))
		else $error("duty not copied at high overflow");

	a_match_low: assert property (
		lin0 && high0_step && cmp0_cnt == cmp0_val
		&& cmp0_cnt != 8'h00 |=> !wave0)
		else $error("pin not cleared on compare match");

	a_freq_toggle: assert property (
		mode0 == tpm_pkg::MODE_FREQ && low0_ovf
		|=> wave0 != $past(wave0))
		else $error("pin did not toggle on low overflow");

	a_freq_reload: assert property (
		mode0 == tpm_pkg::MODE_FREQ && low0_ovf
		&& !wr_at(WR_IN, ADDR_IN, tpm_pkg::A_LOW0)
		&& !wr_at(WR_IN, ADDR_IN, tpm_pkg::A_HIGH0)
		|=> low0_r == $past(high0_r) && $stable(high0_r))
		else $error("mode 2 reload wrong");

	a_t1_hold: assert property (
		mode1 == tpm_pkg::MODE_SPLIT && !WR_IN
		|=> $stable(low1_r) && $stable(high1_r))
		else $error("timer 1 counted in its mode 3");

	a_gate_halt: assert property (
		ctrl_r[tpm_pkg::GATE0_BIT] && !ext_interrupt0_pin_lvl_r && !WR_IN
		|=> $stable(low0_r))
		else $error("gate did not halt timer 0");

	a_split_flag: assert property (
		split0 && high0_ovf |=> stat_r[tpm_pkg::OVF1_BIT] ##1 IRQ_OUT
		|| !mask_r[tpm_pkg::OVF1_BIT] || RD_IN || $past(RD_IN))
		else $error("split high overflow did not flag timer 1");

	a_pin_route: assert property (
		!ctrl_r[tpm_pkg::PWM0_BIT] |=> TIMER0_PIN_OUT)
		else $error("pin driven while pwm disabled");

	c_lin_wrap: cover property (lin0 && high0_ovf ##1 wave0);
	c_freq_tog: cover property (cmp0_tog ##[1:600] cmp0_tog);
	c_split_both: cover property (split0 && low0_ovf ##[1:600] high0_ovf);
	c_irq: cover property ($rose(IRQ_OUT));
endmodule

/* verif/tpm_pin_model.sv */
`timescale 1ns/10ps
// stands in for the load on a timer pin: measures each waveform cycle
module tpm_pin_model (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic pin_in,
	output logic [15:0] period_out,
	output logic [15:0] high_out
);
	logic [15:0] cnt_r;
	logic pin_r;

	// counts from the last rising edge; a pin that never rises keeps old
	// figures, so callers wait several cycles of the wave before reading
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_r <= 16'h0000;
			pin_r <= 1'b1;
			period_out <= 16'h0000;
			high_out <= 16'h0000;
		end else begin
			pin_r <= pin_in;
			cnt_r <= cnt_r + 16'h0001;
			if (pin_in && !pin_r) begin
				period_out <= cnt_r;
				cnt_r <= 16'h0001;
			end
			if (!pin_in && pin_r) begin
				high_out <= cnt_r;
			end
		end
	end
endmodule

/* verif/tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	error_cnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ext0 = 1'b1;
	logic ext1 = 1'b1;
	logic [7:0] rdata;
	logic pin0, pin1, baud, irq;
	logic [15:0] per0, hi0, per1, hi1;
	logic [7:0] d, d2;
	int error_cnt = 0;
	int n_tests = 0;
	int baud_cnt = 0;
	int b0;

	always #5 clk = ~clk;

	tpm_top i_dut (
		.CLK_IN(clk),
		.ARST_N_IN(arst_n),
		.ADDR_IN(addr),
		.WDATA_IN(wdata),
		.WR_IN(wr),
		.RD_IN(rd),
		.RDATA_OUT(rdata),
		.EXT_EXT_INTERRUPT0_PIN_PIN_IN(ext0),
		.EXT_INT1_PIN_IN(ext1),
		.TIMER0_PIN_OUT(pin0),
		.TIMER1_PIN_OUT(pin1),
		.BAUD_TICK_OUT(baud),
		.IRQ_OUT(irq)
	);

	tpm_pin_model i_load0 (
		.clk_in(clk),
		.arst_n_in(arst_n),
		.pin_in(pin0),
		.period_out(per0),
		.high_out(hi0)
	);

	tpm_pin_model i_load1 (
		.clk_in(clk),
		.arst_n_in(arst_n),
		.pin_in(pin1),
		.period_out(per1),
		.high_out(hi1)
	);

	always @(posedge clk)
		if (baud === 1'b1)
			baud_cnt++;

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// data is valid only in the cycle after the strobe edge
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e,
		input string nm);
		logic [7:0] v;
		rd_reg(a, v);
		`CHK(nm, e, v)
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic test_done;
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		`CHK("pin0 idle", 1'b1, pin0)
		`CHK("irq idle", 1'b0, irq)
		chk_rd(tpm_pkg::A_CTRL, 8'h00, "ctrl rst");
		chk_rd(tpm_pkg::A_MODE, 8'h00, "mode rst");
		// linear prescaler, reload FF: one high step per clock
		wr_reg(tpm_pkg::A_MODE, 8'h05);
		wr_reg(tpm_pkg::A_LREL0, 8'hFF);
		wr_reg(tpm_pkg::A_HREL0, 8'h40);
		wr_reg(tpm_pkg::A_CTRL, 8'h11);
		waitc(800);
		`CHK("m1 period", 16'd256, per0)
		`CHK("m1 high", 16'd64, hi0)
		chk_rd(tpm_pkg::A_CMP0, 8'h40, "cmp0");
		// slower reload and prescaler stretch the period
		wr_reg(tpm_pkg::A_LREL0, 8'hFE);
		wr_reg(tpm_pkg::A_PSC, 8'h01);
		waitc(3200);
		`CHK("m1 psc period", 16'd1024, per0)
		`CHK("m1 psc high", 16'd256, hi0)
		// both timers as square-wave generators
		wr_reg(tpm_pkg::A_MODE, 8'h0A);
		wr_reg(tpm_pkg::A_HIGH0, 8'hF8);
		wr_reg(tpm_pkg::A_HIGH1, 8'hF0);
		wr_reg(tpm_pkg::A_LREL1, 8'h5A);
		wr_reg(tpm_pkg::A_HREL1, 8'hA5);
		wr_reg(tpm_pkg::A_CTRL, 8'h33);
		// timer 1 starts from zero: first wrap only after 512 clocks
		waitc(800);
		`CHK("m2 t0 period", 16'd32, per0)
		`CHK("m2 t0 high", 16'd16, hi0)
		`CHK("m2 t1 period", 16'd64, per1)
		`CHK("m2 t1 high", 16'd32, hi1)
		chk_rd(tpm_pkg::A_LREL1, 8'h5A, "scratch lo");
		chk_rd(tpm_pkg::A_HREL1, 8'hA5, "scratch hi");
		b0 = baud_cnt;
		waitc(320);
		`CHK("baud ticks", 10, baud_cnt - b0)
		// split timer 0, timer 1 parked in its own mode 3
		wr_reg(tpm_pkg::A_PSC, 8'h00);
		wr_reg(tpm_pkg::A_MODE, 8'h0F);
		wr_reg(tpm_pkg::A_LREL0, 8'h80);
		wr_reg(tpm_pkg::A_HREL0, 8'h20);
		waitc(800);
		`CHK("split lo period", 16'd256, per0)
		`CHK("split lo high", 16'd128, hi0)
		`CHK("split hi period", 16'd256, per1)
		`CHK("split hi high", 16'd32, hi1)
		rd_reg(tpm_pkg::A_LOW1, d);
		waitc(20);
		rd_reg(tpm_pkg::A_LOW1, d2);
		`CHK("t1 held", d, d2)
		b0 = baud_cnt;
		waitc(300);
		`CHK("no baud m3", 0, baud_cnt - b0)
		// interrupt: raise, clear, mask
		wr_reg(tpm_pkg::A_MASK, 8'h01);
		waitc(300);
		`CHK("irq on", 1'b1, irq)
		// keep the next low wrap well clear of the clear check
		wr_reg(tpm_pkg::A_LOW0, 8'h00);
		rd_reg(tpm_pkg::A_STAT, d);
		`CHK("stat ovf0", 1'b1, d[tpm_pkg::OVF0_BIT])
		waitc(2);
		`CHK("irq cleared", 1'b0, irq)
		wr_reg(tpm_pkg::A_MASK, 8'h00);
		waitc(300);
		`CHK("irq masked", 1'b0, irq)
		// gate low halts the split low channel
		@(posedge clk);
		ext0 <= 1'b0;
		wr_reg(tpm_pkg::A_CTRL, 8'h37);
		waitc(10);
		rd_reg(tpm_pkg::A_LOW0, d);
		waitc(20);
		rd_reg(tpm_pkg::A_LOW0, d2);
		`CHK("gate halt", d, d2)
		@(posedge clk);
		ext0 <= 1'b1;
		waitc(10);
		rd_reg(tpm_pkg::A_LOW0, d2);
		`CHK("gate run", 1'b1, d !== d2)
		// timer 1 restarts when it leaves its mode 3
		wr_reg(tpm_pkg::A_MODE, 8'h0B);
		// let the first wrap pass; prescaler is 0: one wrap per 16 clocks
		waitc(40);
		b0 = baud_cnt;
		waitc(320);
		`CHK("t1 restart", 20, baud_cnt - b0)
		test_done();
	end
endmodule
